// ===== imam_matcher.sv
`timescale 1ns/10ps
module imam_matcher (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [6:0] i_strap_addr,
    input wire imam_pkg::imam_cfg_t i_cfg,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_addr_hit,
    output logic o_rw_read,
    output imam_pkg::imam_kind_t o_hit_kind,
    output logic o_soft_reset_call,
    output logic [7:0] o_ctrl_byte,
    output logic o_ctrl_valid
);

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic scl_m_r, scl_r, scl_d_r, sda_m_r, sda_r, sda_d_r;
    logic [6:0] strap_m_r, strap_r;

    // two stages before use; bus lines are asynchronous to i_clk
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_m_r <= 1'b1;
            scl_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_r <= 1'b1;
            sda_d_r <= 1'b1;
            strap_m_r <= 7'h00;
            strap_r <= 7'h00;
        end else begin
            scl_m_r <= i_scl;
            scl_r <= scl_m_r;
            scl_d_r <= scl_r;
            sda_m_r <= i_sda;
            sda_r <= sda_m_r;
            sda_d_r <= sda_r;
            strap_m_r <= i_strap_addr;
            strap_r <= strap_m_r;
        end
    end

    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_r & ~scl_d_r;
    assign scl_fall = ~scl_r & scl_d_r;
    assign start_cond = scl_r & scl_d_r & sda_d_r & ~sda_r;
    assign stop_cond = scl_r & scl_d_r & ~sda_d_r & sda_r;

    // ------------------------------------------------------------
    // call address table
    // ------------------------------------------------------------
    logic [imam_pkg::NUM_CALLS-1:0][7:0] call_addr_r;
    logic [imam_pkg::NUM_CALLS-1:0] en_r;
    logic [imam_pkg::NUM_CALLS-1:0] match_vec;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] full_byte;

    assign full_byte = {rx_r[6:0], sda_r};

    genvar gi;
    generate
        for (gi = 0; gi < imam_pkg::NUM_CALLS; gi++) begin : g_call
            logic [7:0] addr_nxt;
            logic en_nxt;
            logic sel_hit;

            assign sel_hit = i_cfg.wr && (i_cfg.sel == 2'(gi));

            // volatile: reset restores defaults, writes replace them
            always_comb begin
                addr_nxt = sel_hit ? i_cfg.addr : call_addr_r[gi];
                en_nxt = sel_hit ? i_cfg.en : en_r[gi];
            end

            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    call_addr_r[gi] <= imam_pkg::CALL_ADDR_RST[gi];
                    en_r[gi] <= imam_pkg::CALL_EN_RST[gi];
                end else begin
                    call_addr_r[gi] <= addr_nxt;
                    en_r[gi] <= en_nxt;
                end
            end

            // direction bit ignored; disabled entry never matches
            assign match_vec[gi] = en_r[gi] && (call_addr_r[gi][7:1] == full_byte[7:1]);
        end
    endgenerate

    // ------------------------------------------------------------
    // match priority
    // ------------------------------------------------------------
    logic any_match;
    imam_pkg::imam_kind_t match_kind;

    // soft reset first so a strap equal to it cannot steal the call
    always_comb begin
        any_match = 1'b1;
        match_kind = imam_pkg::KIND_REGULAR;
        if (full_byte == imam_pkg::SOFT_RESET_CALL) begin
            match_kind = imam_pkg::KIND_SOFT;
        end else if (full_byte[7:1] == strap_r) begin
            match_kind = imam_pkg::KIND_REGULAR;
        end else if (match_vec[0]) begin
            match_kind = imam_pkg::KIND_GROUP;
        end else if (match_vec[1]) begin
            match_kind = imam_pkg::KIND_SUB1;
        end else if (match_vec[2]) begin
            match_kind = imam_pkg::KIND_SUB2;
        end else if (match_vec[3]) begin
            match_kind = imam_pkg::KIND_SUB3;
        end else begin
            any_match = 1'b0; // soft call with read bit lands here unless strap is 03h or an enabled entry matches
        end
    end

    // ------------------------------------------------------------
    // receive sequencer
    // ------------------------------------------------------------
    imam_pkg::imam_state_t state_r, state_nxt;
    imam_pkg::imam_kind_t kind_r, kind_nxt;
    logic oe_r, oe_nxt, read_r, read_nxt, hit_r, hit_nxt, soft_r, soft_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic cval_r, cval_nxt;

    // START restarts from anywhere; bit count is for the current byte
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        oe_nxt = oe_r;
        read_nxt = read_r;
        hit_nxt = 1'b0;
        soft_nxt = 1'b0;
        ctrl_nxt = ctrl_r;
        cval_nxt = 1'b0;
        if (start_cond) begin
            state_nxt = imam_pkg::ST_ADDR;
            cnt_nxt = 3'h0;
            oe_nxt = 1'b0;
        end else if (stop_cond) begin
            state_nxt = imam_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                imam_pkg::ST_IDLE, imam_pkg::ST_IGNORE: begin
                    oe_nxt = 1'b0;
                end
                imam_pkg::ST_ADDR, imam_pkg::ST_CTRL: begin
                    if (scl_rise) begin
                        rx_nxt = full_byte;
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == imam_pkg::LAST_BIT) begin
                            if (state_r == imam_pkg::ST_CTRL) begin
                                ctrl_nxt = full_byte;
                                cval_nxt = 1'b1;
                                state_nxt = imam_pkg::ST_CACKW;
                            end else if (any_match) begin
                                kind_nxt = match_kind;
                                read_nxt = full_byte[0];
                                state_nxt = imam_pkg::ST_ACKW;
                            end else begin
                                state_nxt = imam_pkg::ST_IGNORE;
                            end
                        end
                    end
                end
                imam_pkg::ST_ACKW, imam_pkg::ST_CACKW: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b1; // pull data low for the ninth clock
                        state_nxt = (state_r == imam_pkg::ST_ACKW) ? imam_pkg::ST_ACK : imam_pkg::ST_CACK;
                    end
                end
                imam_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        hit_nxt = 1'b1;
                        cnt_nxt = 3'h0;
                        if (kind_r == imam_pkg::KIND_SOFT) begin
                            soft_nxt = 1'b1;
                            state_nxt = imam_pkg::ST_IGNORE;
                        end else if (read_r) begin
                            state_nxt = imam_pkg::ST_IGNORE; // read data path lives elsewhere
                        end else begin
                            state_nxt = imam_pkg::ST_CTRL;
                        end
                    end
                end
                imam_pkg::ST_CACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        state_nxt = imam_pkg::ST_IGNORE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= imam_pkg::ST_IDLE;
            kind_r <= imam_pkg::KIND_REGULAR;
            cnt_r <= 3'h0;
            rx_r <= 8'h00;
            oe_r <= 1'b0;
            read_r <= 1'b0;
            hit_r <= 1'b0;
            soft_r <= 1'b0;
            ctrl_r <= 8'h00;
            cval_r <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            oe_r <= oe_nxt;
            read_r <= read_nxt;
            hit_r <= hit_nxt;
            soft_r <= soft_nxt;
            ctrl_r <= ctrl_nxt;
            cval_r <= cval_nxt;
            o_sda_o <= 1'b0; // open drain: only ever pulls low
        end
    end

    assign o_sda_oe = oe_r;
    assign o_addr_hit = hit_r;
    assign o_rw_read = read_r;
    assign o_hit_kind = kind_r;
    assign o_soft_reset_call = soft_r;
    assign o_ctrl_byte = ctrl_r;
    assign o_ctrl_valid = cval_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic addr_done;
    assign addr_done = (state_r == imam_pkg::ST_ADDR) && scl_rise && (cnt_r == imam_pkg::LAST_BIT);

    AST_REGULAR_ACK: assert property (@(posedge i_clk) disable iff (i_rst)
        (addr_done && full_byte[7:1] == strap_r && full_byte != imam_pkg::SOFT_RESET_CALL)
        |=> (state_r == imam_pkg::ST_ACKW && o_hit_kind == imam_pkg::KIND_REGULAR))
        else $error("strap address not taken");

    AST_RW_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
        (addr_done && any_match) |=> (o_rw_read == $past(sda_r)))
        else $error("direction bit not captured");

    AST_GROUP_ACK: assert property (@(posedge i_clk) disable iff (i_rst)
        (addr_done && en_r[0] && full_byte[7:1] == call_addr_r[0][7:1]) |=> state_r == imam_pkg::ST_ACKW)
        else $error("enabled group call ignored");

    AST_NO_MATCH_IGNORE: assert property (@(posedge i_clk) disable iff (i_rst)
        (addr_done && match_vec == 4'h0 && full_byte[7:1] != strap_r && full_byte != imam_pkg::SOFT_RESET_CALL)
        |=> (state_r == imam_pkg::ST_IGNORE) ##1 !o_sda_oe)
        else $error("unmatched address acknowledged");

    AST_SOFT_READ_NACK: assert property (@(posedge i_clk) disable iff (i_rst)
        (addr_done && full_byte == 8'h07 && match_vec == 4'h0 && strap_r != 7'h03)
        |=> state_r == imam_pkg::ST_IGNORE)
        else $error("soft reset call with read bit acknowledged");

    AST_SUB_IGNORES_LSB: assert property (@(posedge i_clk) disable iff (i_rst)
        (addr_done && en_r[2] && full_byte[7:1] == call_addr_r[2][7:1]) |=> state_r == imam_pkg::ST_ACKW)
        else $error("sub call compare used direction bit");

    AST_ACK_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_r == imam_pkg::ST_ACK && !scl_fall && !start_cond && !stop_cond) |=> o_sda_oe)
        else $error("acknowledge released early");

    AST_CTRL_BYTE: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_r == imam_pkg::ST_CTRL && scl_rise && cnt_r == imam_pkg::LAST_BIT)
        |=> (o_ctrl_valid && o_ctrl_byte == $past(full_byte)) ##1 !o_ctrl_valid)
        else $error("control byte not delivered");

    AST_CFG_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cfg.wr && i_cfg.sel == 2'h0) |=> (call_addr_r[0] == $past(i_cfg.addr) && en_r[0] == $past(i_cfg.en)))
        else $error("group call address write lost");

endmodule : imam_matcher

// ===== imam_pkg.sv
// Functional notes
// - regular address comes from seven strap pins
// - address byte LSB one means read
// - group-call address resets to E0h, rewritable
// - group-call enabled at reset, E0h/E1h acknowledged
// - sub-call addresses reset to E2h, E4h, E8h
// - sub-call addresses disabled at reset
// - soft-reset call byte 06h recognised from start
// - soft-reset call with read bit not acknowledged unless strap is 03h or an enabled call entry matches it
// - reserved strap addresses matched like any other
// - control byte follows an acknowledged write address other than the soft-reset call
package imam_pkg;

    // ------------------------------------------------------------
    // call address table: entry 0 group, entries 1..3 sub-call
    // ------------------------------------------------------------
    localparam int NUM_CALLS = 4;
    localparam logic [NUM_CALLS-1:0][7:0] CALL_ADDR_RST = {8'he8, 8'he4, 8'he2, 8'he0};
    localparam logic [NUM_CALLS-1:0] CALL_EN_RST = 4'h1;
    localparam logic [7:0] SOFT_RESET_CALL = 8'h06;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_REGULAR = 3'h0,
        KIND_GROUP = 3'h1,
        KIND_SUB1 = 3'h2,
        KIND_SUB2 = 3'h3,
        KIND_SUB3 = 3'h4,
        KIND_SOFT = 3'h5
    } imam_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACKW = 3'h2,
        ST_ACK = 3'h3,
        ST_CTRL = 3'h4,
        ST_CACKW = 3'h5,
        ST_CACK = 3'h6,
        ST_IGNORE = 3'h7
    } imam_state_t;

    // local write port for the call address table
    typedef struct packed {
        logic wr;
        logic [1:0] sel;
        logic [7:0] addr;
        logic en;
    } imam_cfg_t;

endpackage : imam_pkg

// ===== imam_bus_ctrl.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// bus controller model: scl low 5 clocks, high 3 (320 ns)
// ------------------------------------------------------------
module imam_bus_ctrl (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    // scl stands high and sda is released between frames
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // start or repeated start, always followed by an address byte
    task automatic start_cond();
        o_sda_pull <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(3);
        o_sda_pull <= 1'b1;
        tick(3);
        o_scl <= 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        tick(2);
        o_sda_pull <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(3);
        o_sda_pull <= 1'b0;
        tick(3);
    endtask : stop_cond

    // msb first; data moves 2 clocks into the low phase so a late ack
    // release by the target never overlaps a rising scl
    task automatic send_byte(input logic [7:0] b, output logic acked);
        for (int i = 7; i >= 0; i--) begin
            tick(2);
            o_sda_pull <= ~b[i];
            tick(3);
            o_scl <= 1'b1;
            tick(3);
            o_scl <= 1'b0;
        end
        tick(2);
        o_sda_pull <= 1'b0;
        tick(3);
        o_scl <= 1'b1;
        tick(2);
        acked = ~i_sda;
        tick(1);
        o_scl <= 1'b0;
    endtask : send_byte
endmodule : imam_bus_ctrl

// ===== i2c_multi_address_matcher_tb_top.sv
`timescale 1ns/10ps
module i2c_multi_address_matcher_tb_top;
    logic i_clk = 1'b0;
    logic i_rst;
    logic [6:0] i_strap_addr;
    imam_pkg::imam_cfg_t i_cfg;
    logic scl;
    logic pull;
    logic sda_wire;
    logic o_sda_o, o_sda_oe, o_addr_hit, o_rw_read, o_soft_reset_call, o_ctrl_valid;
    imam_pkg::imam_kind_t o_hit_kind;
    logic [7:0] o_ctrl_byte;
    logic hit_seen, soft_seen, ctrl_seen;
    logic [7:0] ctrl_got;
    logic [7:0] subs [6] = '{8'he2, 8'he3, 8'he4, 8'he5, 8'he8, 8'he9};
    logic [6:0] odd_straps [4] = '{7'h00, 7'h78, 7'h7c, 7'h71};
    int n_fail = 0;
    int n_checks = 0;

    // ------------------------------------------------------------
    // clock, bus wire and instances
    // ------------------------------------------------------------
    always #20 i_clk = ~i_clk;
    // open-drain data line with pull-up
    assign sda_wire = (o_sda_oe ? o_sda_o : 1'b1) & ~pull;

    imam_matcher uut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_wire),
        .i_strap_addr(i_strap_addr), .i_cfg(i_cfg), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
        .o_addr_hit(o_addr_hit), .o_rw_read(o_rw_read), .o_hit_kind(o_hit_kind),
        .o_soft_reset_call(o_soft_reset_call), .o_ctrl_byte(o_ctrl_byte), .o_ctrl_valid(o_ctrl_valid));
    imam_bus_ctrl u_ctrl (.i_clk(i_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_pull(pull));

    // pulses last one cycle, so hold them until the scenario looks
    always @(posedge i_clk) begin
        if (o_addr_hit === 1'b1) hit_seen <= 1'b1;
        if (o_soft_reset_call === 1'b1) soft_seen <= 1'b1;
        if (o_ctrl_valid === 1'b1) begin
            ctrl_seen <= 1'b1;
            ctrl_got <= o_ctrl_byte;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset();
        i_rst <= 1'b1;
        u_ctrl.tick(20);
        i_rst <= 1'b0;
        u_ctrl.tick(4);
    endtask : do_reset

    task automatic cfg_write(input logic [1:0] sel, input logic [7:0] a, input logic en);
        i_cfg <= '{1'b1, sel, a, en};
        u_ctrl.tick(1);
        i_cfg.wr <= 1'b0;
        u_ctrl.tick(1);
    endtask : cfg_write

    // one framed address byte; a matched write other than the soft call also carries a control byte
    task automatic try_addr(input logic [7:0] b, input logic exp_ack, input imam_pkg::imam_kind_t kind);
        logic acked;
        logic ctrl_on;
        ctrl_on = exp_ack && !b[0] && kind != imam_pkg::KIND_SOFT;
        hit_seen <= 1'b0;
        soft_seen <= 1'b0;
        ctrl_seen <= 1'b0;
        u_ctrl.start_cond();
        u_ctrl.send_byte(b, acked);
        chk({7'h0, acked}, {7'h0, exp_ack});
        if (ctrl_on) begin
            u_ctrl.send_byte(~b, acked);
            chk({7'h0, acked}, 8'h01);
        end
        u_ctrl.stop_cond();
        chk({7'h0, hit_seen}, {7'h0, exp_ack});
        chk({7'h0, ctrl_seen}, {7'h0, ctrl_on});
        if (ctrl_on) chk(ctrl_got, ~b);
        chk({7'h0, soft_seen}, {7'h0, exp_ack && kind == imam_pkg::KIND_SOFT});
        if (exp_ack) begin
            chk({5'h0, o_hit_kind}, {5'h0, kind});
            chk({7'h0, o_rw_read}, {7'h0, b[0]});
        end
    endtask : try_addr

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic scen_strap();
        try_addr({7'h15, 1'b0}, 1'b1, imam_pkg::KIND_REGULAR);
        try_addr({7'h15, 1'b1}, 1'b1, imam_pkg::KIND_REGULAR);
        try_addr({7'h16, 1'b0}, 1'b0, imam_pkg::KIND_REGULAR);
        // reserved values and the E2h sub-call default strapped; never the soft call
        foreach (odd_straps[i]) begin
            i_strap_addr <= odd_straps[i];
            u_ctrl.tick(4);
            try_addr({odd_straps[i], 1'b0}, 1'b1, imam_pkg::KIND_REGULAR);
        end
        i_strap_addr <= 7'h15;
        u_ctrl.tick(4);
    endtask : scen_strap

    task automatic scen_calls();
        try_addr(8'he0, 1'b1, imam_pkg::KIND_GROUP);
        try_addr(8'he1, 1'b1, imam_pkg::KIND_GROUP);
        foreach (subs[i]) try_addr(subs[i], 1'b0, imam_pkg::KIND_REGULAR);
        try_addr(8'h06, 1'b1, imam_pkg::KIND_SOFT);
        try_addr(8'h07, 1'b0, imam_pkg::KIND_REGULAR);
    endtask : scen_calls

    task automatic scen_program();
        cfg_write(2'h1, 8'h52, 1'b1);
        cfg_write(2'h3, 8'h41, 1'b1);
        cfg_write(2'h2, 8'he4, 1'b1);
        cfg_write(2'h0, 8'he0, 1'b0);
        try_addr(8'h52, 1'b1, imam_pkg::KIND_SUB1);
        try_addr(8'he5, 1'b1, imam_pkg::KIND_SUB2);
        try_addr(8'h53, 1'b1, imam_pkg::KIND_SUB1);
        try_addr(8'h40, 1'b1, imam_pkg::KIND_SUB3);
        try_addr(8'he0, 1'b0, imam_pkg::KIND_REGULAR);
        // programmed values are volatile
        do_reset();
        try_addr(8'he0, 1'b1, imam_pkg::KIND_GROUP);
        try_addr(8'h52, 1'b0, imam_pkg::KIND_REGULAR);
        try_addr(8'h40, 1'b0, imam_pkg::KIND_REGULAR);
        try_addr(8'he5, 1'b0, imam_pkg::KIND_REGULAR);
    endtask : scen_program

    // watchdog: a hang is counted and ends the run
    initial begin
        repeat (30000) @(posedge i_clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        // reset stands from time zero; straps at the home address
        i_rst = 1'b1;
        i_strap_addr = 7'h15;
        i_cfg = '0;
        hit_seen = 1'b0;
        soft_seen = 1'b0;
        ctrl_seen = 1'b0;
        ctrl_got = 8'h00;
        @(posedge i_clk);
        do_reset();
        scen_strap();
        scen_calls();
        scen_program();
        give_verdict();
    end
endmodule : i2c_multi_address_matcher_tb_top
